// >>> src/asc_map.svh
// register map, field positions, reset values and timing of the sequence controller
// Operation
// (RULE1) keys four+five: address mode, 0-31, key two exits
// (RULE2) serial port fixed 9600 baud 8N1
// (RULE3) host waits 20 ms between commands
// (RULE4) reset: lamps off, bank 01 shown
// (RULE5) store overwrites earlier setup under key
// (RULE6) state key lights lamp, broadcasts recall
// (RULE7) module key activity clears state lamp
// (RULE8) remote keys recall; fail lamp on failure
// (RULE9) keys three+four: sequencer mode, lamps three+four
// (RULE10) nine sequences of sixteen steps each
// (RULE11) test and delay time in 100 ms units
// (RULE12) sample module fail at test expiry
// (RULE13) wait delay time before next step
// (RULE14) exit during edit ends sequence there
// (RULE15) start recalls steps from zero, exit aborts
// (RULE16) flash pass or fail code at end
// (RULE17) after result start reruns, exit leaves
// (RULE18) recalls copied to cascade output port
// (RULE19) 100 ms tick from system clock
// (RULE20) failure flag cleared at run start
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH
`define ASC_CLK_HZ 100000000
`define ASC_TICK_MS 100
`define ASC_TICK_CYC (`ASC_CLK_HZ / 1000 * `ASC_TICK_MS)
`define ASC_BAUD 9600
`define ASC_BAUD_CYC (`ASC_CLK_HZ / `ASC_BAUD)
`define ASC_CMD_GAP_MS 20
`define ASC_OFS_CTRL 8'h00
`define ASC_OFS_STEP 8'h04
`define ASC_OFS_STAT 8'h08
`define ASC_OFS_TX 8'h0c
`define ASC_OFS_RX 8'h10
`define ASC_SEQS 9
`define ASC_STEPS 16
`define ASC_ADDR_MAX 5'h1f
`define ASC_ADDR_RST 5'h00
`define ASC_BANK_MIN 5'h01
`define ASC_BANK_MAX 5'h1e
`define ASC_BANK_RST 5'h01
`define ASC_SEQ_LEDS 5'h0c
`define ASC_STAT_STEP 4
`define ASC_STAT_FAIL 8
`define ASC_STAT_ADDR 9
`define ASC_STAT_LEN 14
`define ASC_RX_VALID 8
`endif

// >>> src/asc_pkg.sv
// types shared by the sequence controller
package asc_pkg;
	typedef enum logic [2:0] {
		SQ_OFF = 3'b000, SQ_READY = 3'b001, SQ_EDIT = 3'b010, SQ_RECALL = 3'b011,
		SQ_TEST = 3'b100, SQ_DELAY = 3'b101, SQ_RESULT = 3'b110
	} asc_seq_e;
	typedef enum logic [2:0] {
		DS_BANK = 3'b000, DS_ADDR = 3'b001, DS_STEP = 3'b010, DS_PASS = 3'b011, DS_FAIL = 3'b100
	} asc_disp_e;
	typedef struct packed {
		logic store;
		logic [4:0] bank;
		logic [2:0] state;
	} asc_cmd_s;
	typedef struct packed {
		logic [4:0] bank;
		logic [2:0] state;
		logic [6:0] testTime;
		logic [6:0] delayTime;
	} asc_step_s;
endpackage

// >>> src/asc_top.sv
// front-panel controller: state keys, address entry, auto-sequencer, serial port
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "asc_map.svh"
module asc_top #(
	parameter int MODS = 4,
	parameter int TICK_CYC = `ASC_TICK_CYC,
	parameter int BAUD_CYC = `ASC_BAUD_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire logic [4:0] keyState,
	input wire logic keyStore,
	input wire logic keyStart,
	input wire logic keyExit,
	input wire logic keyBankUp,
	input wire logic keyBankDn,
	input wire logic modKeyAny,
	input wire logic [MODS-1:0] moduleFailState,
	input wire logic [4:0] remRecall,
	input wire logic rxd,
	output logic txd,
	output logic [4:0] stateLed,
	output logic failLamp,
	output asc_pkg::asc_disp_e dispMode,
	output logic [7:0] dispVal,
	output logic dispLit,
	output logic [4:0] busAddr,
	output asc_pkg::asc_cmd_s modCmd,
	output logic modCmdValid,
	output asc_pkg::asc_cmd_s cascCmd,
	output logic cascCmdValid
);
	import asc_pkg::*;
	localparam int NI = 17 + MODS;
	localparam int TW = $clog2(TICK_CYC + 1);
	localparam int BW = $clog2(BAUD_CYC + 1);
	logic [NI-1:0] syn1Reg, syn2Reg, prevReg;
	wire logic [NI-1:0] pinVec = {rxd, remRecall, modKeyAny, keyBankDn, keyBankUp, keyExit, keyStart, keyStore,
		keyState, moduleFailState};
	wire logic [NI-1:0] rise = syn2Reg & ~prevReg;
	wire logic [MODS-1:0] failNow = syn2Reg[MODS-1:0];
	wire logic [4:0] stLvl = syn2Reg[MODS+:5];
	wire logic [4:0] stRise = rise[MODS+:5];
	wire logic storeP = rise[MODS+5];
	wire logic startP = rise[MODS+6];
	wire logic exitP = rise[MODS+7];
	wire logic upP = rise[MODS+8];
	wire logic dnP = rise[MODS+9];
	wire logic modP = rise[MODS+10];
	wire logic [4:0] remRise = rise[MODS+11+:5];
	wire logic rxS = syn2Reg[MODS+16];
	wire logic rxFall = prevReg[MODS+16] & ~rxS;
	// lowest pressed key as a 1-based state number
	function automatic logic [2:0] keyNum(input logic [4:0] k);
		keyNum = 3'h0;
		for (int i = 4; i >= 0; i--) begin
			if (k[i]) begin
				keyNum = 3'(i + 1);
			end
		end
	endfunction
	asc_seq_e seqReg;
	logic addrModeReg, tickReg, flashReg, failAccReg, rxValidReg, txBusyReg;
	logic [TW-1:0] tickCntReg;
	logic [4:0] bankReg, editIdxReg;
	logic [3:0] seqSelReg, stepIdxReg;
	logic [6:0] timerReg;
	asc_step_s stepDataReg;
	asc_step_s stepMem [`ASC_SEQS*`ASC_STEPS];
	logic [4:0] lenMem [`ASC_SEQS];
	logic [4:0] setupBank [5];
	logic [7:0] rxDataReg;
	wire logic normal = (seqReg == SQ_OFF) && !addrModeReg;
	wire logic singleKey = $onehot(stLvl);
	wire logic keyRecall = normal && (stRise != 5'h00) && singleKey && !syn2Reg[MODS+5];
	// store gesture: store held, then one state key pressed
	wire logic keyStoreCmd = normal && (stRise != 5'h00) && singleKey && syn2Reg[MODS+5];
	wire logic [7:0] memIdx = 8'(seqSelReg * `ASC_STEPS);
	wire asc_step_s curStep = stepMem[memIdx + 8'(stepIdxReg)];
	wire logic [4:0] curLen = lenMem[seqSelReg];
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			syn1Reg <= '0;
			syn2Reg <= '0;
			prevReg <= '0;
		end else begin
			syn1Reg <= pinVec;
			syn2Reg <= syn1Reg;
			prevReg <= syn2Reg;
		end
	end
	// 100 ms tick and display flash
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tickCntReg <= '0;
			tickReg <= 1'b0;
			flashReg <= 1'b0;
		end else begin
			tickReg <= (tickCntReg == TW'(TICK_CYC - 1)); // see (RULE19)
			tickCntReg <= (tickCntReg == TW'(TICK_CYC - 1)) ? '0 : tickCntReg + 1'b1;
			if (tickReg) begin
				flashReg <= ~flashReg;
			end
		end
	end
	// address entry and bank selection
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			addrModeReg <= 1'b0;
			busAddr <= `ASC_ADDR_RST;
			bankReg <= `ASC_BANK_RST; // see (RULE4)
		end else if (addrModeReg) begin
			if (stRise[1]) begin
				addrModeReg <= 1'b0; // see (RULE1)
			end else if (upP && busAddr != `ASC_ADDR_MAX) begin
				busAddr <= busAddr + 5'h01;
			end else if (dnP && busAddr != 5'h00) begin
				busAddr <= busAddr - 5'h01;
			end
		end else if (seqReg == SQ_OFF) begin
			if (stLvl[3] && stLvl[4]) begin
				addrModeReg <= 1'b1; // see (RULE1)
			end else if (upP && bankReg != `ASC_BANK_MAX) begin
				bankReg <= bankReg + 5'h01;
			end else if (dnP && bankReg != `ASC_BANK_MIN) begin
				bankReg <= bankReg - 5'h01;
			end
		end
	end
	// sequencer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			seqReg <= SQ_OFF;
			editIdxReg <= 5'h00;
			stepIdxReg <= 4'h0;
			timerReg <= 7'h00;
			failAccReg <= 1'b0;
		end else begin
			unique case (seqReg)
				SQ_OFF: begin
					if (!addrModeReg && stLvl[2] && stLvl[3] && !stLvl[4]) begin
						seqReg <= SQ_READY; // see (RULE9)
					end
				end
				SQ_READY, SQ_RESULT: begin
					if (exitP) begin
						seqReg <= SQ_OFF; // see (RULE17)
					end else if (startP) begin
						stepIdxReg <= 4'h0;
						failAccReg <= 1'b0; // see (RULE20)
						seqReg <= (curLen == 5'h00) ? SQ_RESULT : SQ_RECALL; // see (RULE15)
					end else if (storeP && seqReg == SQ_READY) begin
						editIdxReg <= 5'h00;
						seqReg <= SQ_EDIT;
					end
				end
				SQ_EDIT: begin
					if (exitP) begin
						seqReg <= SQ_READY; // see (RULE14)
					end else if (storeP) begin
						editIdxReg <= editIdxReg + 5'h01;
						if (editIdxReg == 5'(`ASC_STEPS - 1)) begin
							seqReg <= SQ_READY;
						end
					end
				end
				SQ_RECALL: begin
					timerReg <= curStep.testTime;
					seqReg <= exitP ? SQ_READY : SQ_TEST;
				end
				SQ_TEST: begin
					if (exitP) begin
						seqReg <= SQ_READY; // see (RULE15)
					end else if (tickReg) begin
						if (timerReg <= 7'h01) begin
							failAccReg <= failAccReg | (|failNow); // see (RULE12)
							timerReg <= curStep.delayTime;
							seqReg <= SQ_DELAY;
						end else begin
							timerReg <= timerReg - 7'h01; // see (RULE11)
						end
					end
				end
				SQ_DELAY: begin
					if (exitP) begin
						seqReg <= SQ_READY;
					end else if (tickReg) begin
						if (timerReg <= 7'h01) begin
							if (5'(stepIdxReg) == curLen - 5'h01) begin
								seqReg <= SQ_RESULT; // see (RULE16)
							end else begin
								stepIdxReg <= stepIdxReg + 4'h1; // see (RULE13)
								seqReg <= SQ_RECALL;
							end
						end else begin
							timerReg <= timerReg - 7'h01;
						end
					end
				end
				default: seqReg <= SQ_OFF;
			endcase
		end
	end
	// sequence store and setup store
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `ASC_SEQS * `ASC_STEPS; i++) begin
				stepMem[i] <= '0;
			end
			for (int i = 0; i < `ASC_SEQS; i++) begin
				lenMem[i] <= 5'h00;
			end
			for (int i = 0; i < 5; i++) begin
				setupBank[i] <= `ASC_BANK_RST;
			end
		end else begin
			if (seqReg == SQ_EDIT && storeP && !exitP) begin
				stepMem[memIdx + 8'(editIdxReg)] <= stepDataReg; // see (RULE10)
				if (editIdxReg == 5'(`ASC_STEPS - 1)) begin
					lenMem[seqSelReg] <= 5'(`ASC_STEPS);
				end
			end else if (seqReg == SQ_EDIT && exitP) begin
				lenMem[seqSelReg] <= editIdxReg; // see (RULE14)
			end
			if (keyStoreCmd) begin
				setupBank[keyNum(stLvl) - 3'h1] <= bankReg; // see (RULE5)
			end
		end
	end
	// commands to modules and cascade port
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			modCmd <= '0;
			modCmdValid <= 1'b0;
			cascCmd <= '0;
			cascCmdValid <= 1'b0;
		end else begin
			modCmdValid <= 1'b0;
			cascCmdValid <= 1'b0;
			if (seqReg == SQ_RECALL) begin
				modCmd <= '{1'b0, curStep.bank, curStep.state}; // see (RULE15)
				modCmdValid <= 1'b1;
				cascCmd <= '{1'b0, curStep.bank, curStep.state};
				cascCmdValid <= 1'b1;
			end else if (keyStoreCmd) begin
				modCmd <= '{1'b1, bankReg, keyNum(stLvl)};
				modCmdValid <= 1'b1;
			end else if (keyRecall || (normal && remRise != 5'h00)) begin
				modCmd <= '{1'b0, setupBank[keyNum(keyRecall ? stRise : remRise) - 3'h1],
					keyNum(keyRecall ? stRise : remRise)}; // see (RULE6) (RULE8)
				modCmdValid <= 1'b1;
				cascCmd <= '{1'b0, setupBank[keyNum(keyRecall ? stRise : remRise) - 3'h1],
					keyNum(keyRecall ? stRise : remRise)}; // see (RULE18)
				cascCmdValid <= 1'b1;
			end
		end
	end
	// lamps and display
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stateLed <= 5'h00; // see (RULE4)
			failLamp <= 1'b0;
			dispMode <= DS_BANK;
			dispVal <= 8'h01;
			dispLit <= 1'b1;
		end else begin
			failLamp <= |failNow; // see (RULE8)
			if (seqReg != SQ_OFF) begin
				stateLed <= `ASC_SEQ_LEDS; // see (RULE9)
			end else if (modP) begin
				stateLed <= 5'h00; // see (RULE7)
			end else if (keyRecall || (normal && remRise != 5'h00)) begin
				stateLed <= 5'h01 << (keyNum(keyRecall ? stRise : remRise) - 3'h1); // see (RULE6)
			end else if (stateLed == `ASC_SEQ_LEDS) begin
				// sequencer lamps dropped once the mode is left
				stateLed <= 5'h00; // see (RULE9)
			end
			dispLit <= 1'b1;
			if (addrModeReg) begin
				dispMode <= DS_ADDR;
				dispVal <= {3'h0, busAddr};
			end else if (seqReg == SQ_RESULT) begin
				dispMode <= failAccReg ? DS_FAIL : DS_PASS; // see (RULE16)
				dispVal <= 8'h00;
				dispLit <= flashReg;
			end else if (seqReg == SQ_EDIT) begin
				dispMode <= DS_STEP;
				dispVal <= {3'h0, editIdxReg};
			end else if (seqReg != SQ_OFF) begin
				dispMode <= DS_STEP;
				dispVal <= {4'h0, stepIdxReg};
			end else begin
				dispMode <= DS_BANK;
				dispVal <= {3'h0, bankReg};
			end
		end
	end
	// serial port, fixed 8N1
	logic [BW-1:0] txCntReg, rxCntReg;
	logic [3:0] txBitReg, rxBitReg;
	logic [9:0] txShReg;
	logic [7:0] rxShReg;
	logic rxBusyReg;
	wire logic txGo = regWr && regAddr == `ASC_OFS_TX && !txBusyReg;
	wire logic rxTake = regRd && regAddr == `ASC_OFS_RX;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			txBusyReg <= 1'b0;
			txShReg <= 10'h3ff;
			txCntReg <= '0;
			txBitReg <= 4'h0;
			txd <= 1'b1;
		end else if (txGo) begin
			txBusyReg <= 1'b1;
			txShReg <= {1'b1, regWdata[7:0], 1'b0}; // see (RULE2)
			txCntReg <= BW'(BAUD_CYC - 1);
			txBitReg <= 4'h0;
			txd <= 1'b0;
		end else if (txBusyReg) begin
			if (txCntReg == '0) begin
				txCntReg <= BW'(BAUD_CYC - 1);
				txBitReg <= txBitReg + 4'h1;
				txShReg <= {1'b1, txShReg[9:1]};
				txd <= txShReg[1];
				if (txBitReg == 4'h9) begin
					txBusyReg <= 1'b0;
					txd <= 1'b1;
				end
			end else begin
				txCntReg <= txCntReg - 1'b1;
			end
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rxBusyReg <= 1'b0;
			rxCntReg <= '0;
			rxBitReg <= 4'h0;
			rxShReg <= 8'h00;
			rxDataReg <= 8'h00;
			rxValidReg <= 1'b0;
		end else begin
			if (rxTake) begin
				rxValidReg <= 1'b0;
			end
			if (!rxBusyReg) begin
				if (rxFall) begin
					rxBusyReg <= 1'b1;
					rxCntReg <= BW'(BAUD_CYC / 2);
					rxBitReg <= 4'h0;
				end
			end else if (rxCntReg != '0) begin
				rxCntReg <= rxCntReg - 1'b1;
			end else begin
				rxCntReg <= BW'(BAUD_CYC - 1);
				rxBitReg <= rxBitReg + 4'h1;
				if (rxBitReg == 4'h0 && rxS) begin
					rxBusyReg <= 1'b0;
				end else if (rxBitReg == 4'h9) begin
					rxBusyReg <= 1'b0;
					if (rxS) begin
						rxDataReg <= rxShReg; // see (RULE2)
						rxValidReg <= 1'b1;
					end
				end else if (rxBitReg != 4'h0) begin
					rxShReg <= {rxS, rxShReg[7:1]};
				end
			end
		end
	end
	// register port
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			seqSelReg <= 4'h0;
			stepDataReg <= '0;
			regRdata <= 32'h0;
		end else begin
			if (regWr && regAddr == `ASC_OFS_CTRL && regWdata[3:0] < 4'(`ASC_SEQS)) begin
				seqSelReg <= regWdata[3:0];
			end
			if (regWr && regAddr == `ASC_OFS_STEP) begin
				stepDataReg <= regWdata[21:0];
			end
			regRdata <= 32'h0;
			if (regRd) begin
				unique case (regAddr)
					`ASC_OFS_CTRL: regRdata <= {28'h0, seqSelReg};
					`ASC_OFS_STEP: regRdata <= {10'h0, stepDataReg};
					`ASC_OFS_STAT: regRdata <= {13'h0, curLen, busAddr, failAccReg, stepIdxReg, addrModeReg, seqReg};
					`ASC_OFS_TX: regRdata <= {31'h0, txBusyReg};
					`ASC_OFS_RX: regRdata <= {23'h0, rxValidReg, rxDataReg};
					default: regRdata <= 32'h0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/asc_asserts.sv
// assertion checker for the sequence controller ports
`timescale 1ns/100ps
`default_nettype none
module asc_asserts
	import asc_pkg::*;
#(
	parameter int MODS = 4
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire logic modKeyAny,
	input wire logic [MODS-1:0] moduleFailState,
	input wire logic [4:0] stateLed,
	input wire logic failLamp,
	input wire asc_pkg::asc_disp_e dispMode,
	input wire logic [7:0] dispVal,
	input wire logic dispLit,
	input wire logic [4:0] busAddr,
	input wire asc_pkg::asc_cmd_s modCmd,
	input wire logic modCmdValid,
	input wire asc_pkg::asc_cmd_s cascCmd,
	input wire logic cascCmdValid
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire logic showRes = dispMode == DS_PASS || dispMode == DS_FAIL;
	property p_rst_view; $fell(rst) |-> stateLed == 5'h00 && dispMode == DS_BANK && dispVal == 8'h01; endproperty
	a_rst_view: assert property (p_rst_view) else $error("reset view wrong");
	property p_cmd_pulse; modCmdValid |=> !modCmdValid; endproperty
	a_cmd_pulse: assert property (p_cmd_pulse) else $error("command valid too long");
	property p_casc_copy; cascCmdValid |-> modCmdValid && !cascCmd.store && cascCmd == modCmd; endproperty
	a_casc_copy: assert property (p_casc_copy) else $error("cascade copy wrong");
	property p_lamp; cascCmdValid && dispMode == DS_BANK |-> stateLed == 5'h01 << (cascCmd.state - 3'h1); endproperty
	a_lamp: assert property (p_lamp) else $error("recall lamp wrong");
	property p_dark; $rose(modKeyAny) && dispMode == DS_BANK |-> ##[2:6] stateLed == 5'h00; endproperty
	a_dark: assert property (p_dark) else $error("lamp not cleared");
	property p_fail_on; (|moduleFailState)[*5] |-> failLamp; endproperty
	a_fail_on: assert property (p_fail_on) else $error("fail lamp dark");
	property p_fail_off; (moduleFailState == '0)[*5] |-> !failLamp; endproperty
	a_fail_off: assert property (p_fail_off) else $error("fail lamp stuck");
	property p_res_lamps; showRes |-> stateLed[3:2] == 2'b11; endproperty
	a_res_lamps: assert property (p_res_lamps) else $error("sequencer lamps off");
	property p_lit; !showRes |-> dispLit; endproperty
	a_lit: assert property (p_lit) else $error("display flashing outside result");
	property p_addr_show; dispMode == DS_ADDR |-> dispVal == {3'h0, $past(busAddr)}; endproperty
	a_addr_show: assert property (p_addr_show) else $error("address not shown");
	property p_rd_idle; !$past(regRd) |-> regRdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	c_recall: cover property (cascCmdValid);
	c_pass: cover property (dispMode == DS_PASS);
	c_fail: cover property (dispMode == DS_FAIL);
endmodule
bind asc_top asc_asserts #(.MODS(MODS)) u_asc_asserts (.mclk(mclk), .rst(rst), .regRd(regRd), .regRdata(regRdata),
	.modKeyAny(modKeyAny), .moduleFailState(moduleFailState), .stateLed(stateLed), .failLamp(failLamp),
	.dispMode(dispMode), .dispVal(dispVal), .dispLit(dispLit), .busAddr(busAddr), .modCmd(modCmd),
	.modCmdValid(modCmdValid), .cascCmd(cascCmd), .cascCmdValid(cascCmdValid));
`default_nettype wire

// >>> tb/asc_load_model.sv
// behavioural load modules on the backplane
`timescale 1ns/100ps
`default_nettype none
module asc_load_model
	import asc_pkg::*;
#(
	parameter int MODS = 4
) (
	input wire logic mclk,
	input wire logic rst,
	input wire asc_pkg::asc_cmd_s modCmd,
	input wire logic modCmdValid,
	input wire logic [2:0] badState,
	input wire logic keyPoke,
	output logic [MODS-1:0] moduleFailState,
	output logic modKeyAny
);
	logic [2:0] heldState;
	// all modules take the same broadcast recall
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			heldState <= 3'h0;
		end else if (modCmdValid && !modCmd.store) begin
			heldState <= modCmd.state;
		end
	end
	// fail level follows the recalled setup, steady through the test time
	assign moduleFailState = {MODS{heldState == badState}};
	always_ff @(posedge mclk) modKeyAny <= keyPoke;
endmodule
`default_nettype wire

// >>> tb/asc_top_tb.sv
// self-checking bench for the sequence controller
`timescale 1ns/100ps
`default_nettype none
module asc_top_tb;
	import asc_pkg::*;
	localparam int TICK = 20;
	localparam int BAUD = 16;
	localparam logic [9:0] FRAME = {1'b1, 8'ha5, 1'b0};
	logic mclk, rst, regWr, regRd, txd, failLamp, dispLit, modCmdValid, cascCmdValid, modKeyAny, keyPoke;
	logic [7:0] regAddr, dispVal;
	logic [31:0] regWdata, regRdata, rv;
	logic [9:0] keys;
	logic [4:0] remRecall, stateLed, busAddr;
	logic [3:0] moduleFailState;
	logic [2:0] badState;
	asc_disp_e dispMode;
	asc_cmd_s modCmd, cascCmd;
	asc_cmd_s mq[$];
	int tq[$];
	int bad_count, samples_checked, cyc, seed;
	asc_top #(.MODS(4), .TICK_CYC(TICK), .BAUD_CYC(BAUD)) uut (.mclk(mclk), .rst(rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .keyState(keys[4:0]),
		.keyStore(keys[5]), .keyStart(keys[6]), .keyExit(keys[7]), .keyBankUp(keys[8]), .keyBankDn(keys[9]),
		.modKeyAny(modKeyAny), .moduleFailState(moduleFailState), .remRecall(remRecall), .rxd(txd), .txd(txd),
		.stateLed(stateLed), .failLamp(failLamp), .dispMode(dispMode), .dispVal(dispVal), .dispLit(dispLit),
		.busAddr(busAddr), .modCmd(modCmd), .modCmdValid(modCmdValid), .cascCmd(cascCmd),
		.cascCmdValid(cascCmdValid));
	asc_load_model #(.MODS(4)) loads (.mclk(mclk), .rst(rst), .modCmd(modCmd), .modCmdValid(modCmdValid),
		.badState(badState), .keyPoke(keyPoke), .moduleFailState(moduleFailState), .modKeyAny(modKeyAny));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input bit ok, input string m);
		samples_checked++;
		if (!ok) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 rv = regRdata;
	endtask
	// first key set rises, then the full chord
	task automatic press(input logic [9:0] first, input logic [9:0] chord);
		@(posedge mclk);
		keys <= first;
		tick(5);
		keys <= chord;
		tick(6);
		keys <= 10'h0;
		tick(6);
	endtask
	task automatic done(input string n);
		tick(8);
		chk(mq.size() == 0, "commands missing");
		$display("test %s done", n);
	endtask
	// expected command queue against every broadcast
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (modCmdValid === 1'b1) begin
			tq.push_back(cyc);
			chk(mq.size() != 0 && modCmd === mq.pop_front(), "command mismatch");
		end
		if (cascCmdValid === 1'b1) begin
			chk(cascCmd === modCmd && modCmdValid === 1'b1, "cascade differs");
		end
		if (cyc == 30000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		seed = 32'ha257;
		rst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		keyPoke = 1'b0;
		regAddr = 8'h00;
		regWdata = 32'h0;
		keys = 10'h0;
		remRecall = 5'h0;
		badState = 3'h7;
		cyc = 0;
		tick(3);
		rst <= 1'b0;
		tick(1);
		chk(stateLed === 5'h00 && dispMode === DS_BANK && dispVal === 8'h01 && txd === 1'b1, "reset");
		rd(8'h40);
		chk(rv === 32'h0, "unmapped read");
		wr(8'h00, 32'h9 + ($unsigned($random(seed)) % 32'h7));
		rd(8'h00);
		chk(rv[3:0] === 4'h0, "select above nine taken");
		wr(8'h00, 32'h8);
		rd(8'h00);
		chk(rv[3:0] === 4'h8, "ninth sequence refused");
		wr(8'h00, 32'h0);
		wr(8'h0c, {24'h0, FRAME[8:1]});
		tick(BAUD / 2);
		for (int i = 0; i < 10; i++) begin
			chk(txd === FRAME[i], "serial frame");
			tick(BAUD);
		end
		// frame looped back into the receiver
		rd(8'h10);
		chk(rv[8:0] === {1'b1, FRAME[8:1]}, "serial receive");
		rd(8'h10);
		chk(rv[8:0] === {1'b0, FRAME[8:1]}, "receive valid kept");
		done("bus");
		mq.push_back({1'b1, 5'h01, 3'h1});
		press(10'h020, 10'h021);
		press(10'h100, 10'h100);
		chk(dispVal === 8'h02, "bank step");
		mq.push_back({1'b1, 5'h02, 3'h1});
		press(10'h020, 10'h021);
		mq.push_back({1'b0, 5'h02, 3'h1});
		press(10'h001, 10'h001);
		chk(stateLed === 5'h01, "lamp one");
		keyPoke <= 1'b1;
		tick(8);
		keyPoke <= 1'b0;
		chk(stateLed === 5'h00, "lamp kept");
		badState <= 3'h3;
		mq.push_back({1'b1, 5'h02, 3'h3});
		press(10'h020, 10'h024);
		mq.push_back({1'b0, 5'h02, 3'h3});
		remRecall <= 5'h04;
		tick(12);
		remRecall <= 5'h00;
		chk(failLamp === 1'b1, "fail lamp dark");
		mq.push_back({1'b0, 5'h02, 3'h1});
		press(10'h001, 10'h001);
		chk(failLamp === 1'b0, "fail lamp stuck");
		done("recall");
		press(10'h018, 10'h018);
		chk(dispMode === DS_ADDR, "address mode");
		press(10'h100, 10'h100);
		press(10'h100, 10'h100);
		press(10'h200, 10'h200);
		press(10'h001, 10'h001);
		chk(busAddr === 5'h01, "address step");
		press(10'h002, 10'h002);
		rd(8'h08);
		chk(dispMode === DS_BANK && rv[13:9] === 5'h01, "address exit");
		done("address");
		press(10'h00c, 10'h00c);
		chk(stateLed === 5'h0c, "sequencer lamps");
		press(10'h020, 10'h020);
		wr(8'h04, {10'h0, 5'h01, 3'h1, 7'h02, 7'h03});
		press(10'h020, 10'h020);
		wr(8'h04, {10'h0, 5'h01, 3'h2, 7'h01, 7'h01});
		press(10'h020, 10'h020);
		press(10'h080, 10'h080);
		rd(8'h08);
		chk(rv[18:14] === 5'h02, "sequence length");
		mq.push_back({1'b0, 5'h01, 3'h1});
		press(10'h040, 10'h040);
		press(10'h080, 10'h080);
		tick(150);
		chk(dispMode === DS_STEP, "abort ignored");
		for (int r = 0; r < 2; r++) begin
			badState <= r ? 3'h7 : 3'h2;
			mq.push_back({1'b0, 5'h01, 3'h1});
			mq.push_back({1'b0, 5'h01, 3'h2});
			press(10'h040, 10'h040);
			for (int i = 0; i < 600 && dispMode !== DS_PASS && dispMode !== DS_FAIL; i++) begin
				@(posedge mclk);
			end
			chk(dispMode === (r ? DS_PASS : DS_FAIL), "run result");
			chk(tq[$] - tq[$-1] >= 3 * TICK && tq[$] - tq[$-1] <= 5 * TICK + 5, "step time");
			done("run");
		end
		press(10'h080, 10'h080);
		chk(dispMode === DS_BANK && stateLed === 5'h00, "result exit");
		done("sequencer");
		tally_and_finish();
	end
endmodule
`default_nettype wire
